// ---- design/rmcd_top.sv ----
/*
 * Control-word decoder for a sixteen-way relay multiplexer unit.
 * Holds the synchronised word, the latched selection, the one-hot relay
 * drive, the matching indicators and a relay settle timer.
 * Assumes a host that presents an 8-bit word on plain pins, held for at
 * least one of its sample periods (several clocks here).
 */
`timescale 1ns/1ps
`include "rmcd_defs.svh"

module rmcd_top
    import rmcd_pkg::*;
#(
    parameter rmcd_pkg::rmcd_addr_t DEV_ADDR   = `RMCD_DEV_ADDR_DEF,
    parameter int                   SETTLE_CYC = `RMCD_SETTLE_CYC
)
(
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 nrst_i,
    // control word pins from the host
    input  wire rmcd_pkg::rmcd_word_t ctrl_word_i,
    // relay drive: one-hot routing of the common path
    output rmcd_pkg::rmcd_relay_t     relay_en_o,
    // channel indicators
    output rmcd_pkg::rmcd_relay_t     chan_led_o,
    // status
    output logic                      chan_active_o,
    output rmcd_pkg::rmcd_chan_t      chan_num_o,
    output logic                      settling_o
);
    import rmcd_pkg::*;

    localparam int CNT_W = $clog2(SETTLE_CYC + 1);
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC);

    typedef struct packed {
        rmcd_chan_t       sel_chan;
        rmcd_addr_t       sel_addr;
        logic             set_prev;
        rmcd_relay_t      relay;
        rmcd_relay_t      led;
        logic             active;
        rmcd_chan_t       chan;
        logic [CNT_W-1:0] settle_cnt;
        logic             settling;
    } rmcd_state_t;

    rmcd_state_t st_r;
    rmcd_state_t st_nxt;
    rmcd_word_t  word;

    // channel number to one-hot relay vector
    function automatic rmcd_relay_t chan_onehot(input rmcd_chan_t c);
        rmcd_relay_t v;
        v    = '0;
        v[c] = 1'b1;
        return v;
    endfunction

    // field extraction
    function automatic rmcd_chan_t word_chan(input rmcd_word_t w);
        return w[`RMCD_CHAN_MSB:`RMCD_CHAN_LSB];
    endfunction

    function automatic rmcd_addr_t word_addr(input rmcd_word_t w);
        return w[`RMCD_ADDR_MSB:`RMCD_ADDR_LSB];
    endfunction

    // pins pass two flip-flops before any decoding
    rmcd_sync u_sync (
        .sys_clk_i   (sys_clk_i),
        .nrst_i      (nrst_i),
        .pin_word_i  (ctrl_word_i),
        .sync_word_o (word)
    );

    // decode events of the current word
    logic set_bit;
    logic off_bit;
    logic set_rise;
    logic off_hit;
    logic set_hit;

    assign set_bit  = word[`RMCD_SET_BIT];
    assign off_bit  = word[`RMCD_OFF_BIT];
    assign set_rise = set_bit && !st_r.set_prev;
    assign off_hit  = off_bit && (word_addr(word) == DEV_ADDR);
    assign set_hit  = set_rise && (st_r.sel_addr == DEV_ADDR);

    // next state: latch selection, apply set / all-off, run settle timer
    always_comb begin
        st_nxt          = st_r;
        st_nxt.set_prev = set_bit;
        // selection words carry neither strobe; the strobe word may not
        if (!set_bit && !off_bit) begin
            st_nxt.sel_chan = word_chan(word);
            st_nxt.sel_addr = word_addr(word);
        end
        // all-off outranks a simultaneous set
        if (off_hit) begin
            st_nxt.relay  = '0;
            st_nxt.active = 1'b0;
        end else if (set_hit) begin
            st_nxt.relay  = chan_onehot(st_r.sel_chan);
            st_nxt.active = 1'b1;
            st_nxt.chan   = st_r.sel_chan;
        end
        st_nxt.led = st_nxt.relay;
        // any change of routing restarts the settle window
        if (st_nxt.relay != st_r.relay) begin
            st_nxt.settle_cnt = SETTLE_LOAD;
            st_nxt.settling   = 1'b1;
        end else if (st_r.settle_cnt != '0) begin
            st_nxt.settle_cnt = st_r.settle_cnt - 1'b1;
            st_nxt.settling   = (st_r.settle_cnt != CNT_W'(1));
        end else begin
            st_nxt.settling   = 1'b0;
        end
    end

    // state register; reset leaves every channel open
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_r.sel_chan   <= '0;
            st_r.sel_addr   <= '0;
            st_r.set_prev   <= 1'b0;
            st_r.relay      <= `RMCD_RELAY_RST;
            st_r.led        <= `RMCD_RELAY_RST;
            st_r.active     <= 1'b0;
            st_r.chan       <= '0;
            st_r.settle_cnt <= '0;
            st_r.settling   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign relay_en_o    = st_r.relay;
    assign chan_led_o    = st_r.led;
    assign chan_active_o = st_r.active;
    assign chan_num_o    = st_r.chan;
    assign settling_o    = st_r.settling;

    // never two relays closed
    property p_one_hot;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        $onehot0(relay_en_o);
    endproperty
    a_one_hot: assert property (p_one_hot)
        else $error("more than one relay closed");

    // indicators track the relays
    property p_led_match;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        chan_led_o == relay_en_o && chan_active_o == (|relay_en_o);
    endproperty
    a_led_match: assert property (p_led_match)
        else $error("indicators differ from relay drive");

    // set strobe closes the earlier selected channel
    property p_set;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        set_hit && !off_hit |=> relay_en_o == chan_onehot($past(st_r.sel_chan)) && chan_num_o == $past(st_r.sel_chan);
    endproperty
    a_set: assert property (p_set)
        else $error("set strobe did not close selected channel");

    // selection word then strobe word selects the first word's channel
    property p_sequence;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (!set_bit && !off_bit && word_addr(word) == DEV_ADDR) ##1
        (set_bit && !off_bit) |=> relay_en_o == chan_onehot($past(word_chan(word), 2));
    endproperty
    a_sequence: assert property (p_sequence)
        else $error("strobe did not apply preceding selection");

    // all-off for this unit opens every relay
    property p_off;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        off_hit |=> relay_en_o == '0 && !chan_active_o;
    endproperty
    a_off: assert property (p_off)
        else $error("all-off did not open relays");

    // words for other units leave the relays alone
    property p_other_addr;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (word_addr(word) != DEV_ADDR) && (st_r.sel_addr != DEV_ADDR) |=> $stable(relay_en_o);
    endproperty
    a_other_addr: assert property (p_other_addr)
        else $error("relays changed for another unit address");

    // dark after reset release
    property p_reset_dark;
        @(posedge sys_clk_i)
        !$past(nrst_i) |-> relay_en_o == '0 && chan_led_o == '0;
    endproperty
    a_reset_dark: assert property (p_reset_dark)
        else $error("channel active straight after reset");

    // routing change raises the settle flag in the same cycle and the next
    property p_settle;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        $changed(relay_en_o) |-> settling_o [*2];
    endproperty
    a_settle: assert property (p_settle)
        else $error("settle flag not raised after switching");
endmodule

// ---- design/rmcd_defs.svh ----
/*
 * Constants of the relay multiplexer control-word decoder: field positions
 * of the eight-bit control word, reset values and timing figures.
 * Assumes inclusion by its bare name; definitions only.
 */
`ifndef RMCD_DEFS_SVH
`define RMCD_DEFS_SVH

// control word layout
`define RMCD_WORD_W        8
`define RMCD_CHAN_LSB      0
`define RMCD_CHAN_MSB      3
`define RMCD_ADDR_LSB      4
`define RMCD_ADDR_MSB      5
`define RMCD_SET_BIT       6
`define RMCD_OFF_BIT       7

// channel count and default unit address
`define RMCD_NUM_CHAN      16
`define RMCD_DEV_ADDR_DEF  2'h0

// reset values
`define RMCD_RELAY_RST     16'h0000
`define RMCD_WORD_RST      8'h00

// timing: relay settle time in ns, clock period in ns
`define RMCD_SETTLE_NS     1000000
`define RMCD_CLK_NS        25
`define RMCD_SETTLE_CYC    ((`RMCD_SETTLE_NS + `RMCD_CLK_NS - 1) / `RMCD_CLK_NS)

`endif

// ---- design/rmcd_pkg.sv ----
/*
 * Types shared by the control-word decoder and its input synchroniser.
 * Assumes rmcd_defs.svh is reachable on the include path.
 */
`include "rmcd_defs.svh"

package rmcd_pkg;
    // one control word as presented on the pins
    typedef logic [`RMCD_WORD_W-1:0]                  rmcd_word_t;
    // channel number field
    typedef logic [`RMCD_CHAN_MSB-`RMCD_CHAN_LSB:0]   rmcd_chan_t;
    // unit address field
    typedef logic [`RMCD_ADDR_MSB-`RMCD_ADDR_LSB:0]   rmcd_addr_t;
    // one-hot relay / indicator vector
    typedef logic [`RMCD_NUM_CHAN-1:0]                rmcd_relay_t;
endpackage

// ---- design/rmcd_sync.sv ----
/*
 * Two-flip-flop synchroniser for the parallel control word pins.
 * Assumes each pin is a slow level from another device; no bus coherence
 * is promised, the decoder relies on the host holding fields steady.
 */
`timescale 1ns/1ps
`include "rmcd_defs.svh"

module rmcd_sync
    import rmcd_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              nrst_i,
    // pins in, synchronised word out
    input  wire rmcd_pkg::rmcd_word_t pin_word_i,
    output rmcd_pkg::rmcd_word_t   sync_word_o
);
    import rmcd_pkg::*;

    typedef struct packed {
        rmcd_word_t meta;
        rmcd_word_t stable;
    } rmcd_sync_t;

    rmcd_sync_t st_r;
    rmcd_sync_t st_nxt;

    // first stage feeds only the second
    always_comb begin
        st_nxt        = st_r;
        st_nxt.meta   = pin_word_i;
        st_nxt.stable = st_r.meta;
    end

    // register stages
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_r <= '{meta: `RMCD_WORD_RST, stable: `RMCD_WORD_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_word_o = st_r.stable;
endmodule

// ---- verif/rmcd_host.sv ----
/*
 * Host model: drives the eight control word pins at the falling edge.
 * Assumes the unit synchronises the pins; each word stands for a host sample.
 */
`timescale 1ns/1ps

module rmcd_host
    import rmcd_pkg::*;
#(
    parameter int SAMPLE = 4,
    parameter int SETTLE = 12
)
(
    // clock
    input  wire logic            sys_clk_i,
    // control word pins
    output rmcd_pkg::rmcd_word_t ctrl_word_o
);
    initial ctrl_word_o = 8'h00;

    // present one word for n host clocks
    task automatic put(input rmcd_word_t w, input int n);
        @(negedge sys_clk_i);
        ctrl_word_o = w;
        repeat (n) @(negedge sys_clk_i);
    endtask

    // selection first, strobe one sample later
    task automatic set_chan(input rmcd_chan_t ch, input rmcd_addr_t a);
        put({2'b00, a, ch}, SAMPLE);
        put(8'h40, SAMPLE);
    endtask

    // all-off word for one unit address
    task automatic all_off(input rmcd_addr_t a);
        put({2'b10, a, 4'h0}, SAMPLE);
    endtask

    // strobe low, wait for the relays to settle
    task automatic settle();
        put(8'h00, SETTLE);
    endtask
endmodule

// ---- verif/tb.sv ----
/*
 * Self-checking bench for the control word decoder with a host model.
 * Assumes a short settle count so the run stays brief.
 */
`timescale 1ns/1ps

module tb;
    import rmcd_pkg::*;
    localparam rmcd_addr_t DEV    = 2'h1;
    localparam int         SETTLE = 8;

    logic        sys_clk_i;
    logic        nrst_i;
    rmcd_word_t  ctrl_word;
    rmcd_relay_t relay_en;
    rmcd_relay_t chan_led;
    logic        chan_active;
    rmcd_chan_t  chan_num;
    logic        settling;
    int          mismatches;
    int          checked;

    rmcd_host #(.SAMPLE(4), .SETTLE(SETTLE + 4)) host (.sys_clk_i(sys_clk_i), .ctrl_word_o(ctrl_word));
    rmcd_top #(.DEV_ADDR(DEV), .SETTLE_CYC(SETTLE)) DUT (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ctrl_word_i(ctrl_word), .relay_en_o(relay_en),
        .chan_led_o(chan_led), .chan_active_o(chan_active), .chan_num_o(chan_num), .settling_o(settling));

    // clock generator
    always #12.5 sys_clk_i = ~sys_clk_i;

    // compare tasks
    task automatic cmp_relay(input rmcd_relay_t got, input rmcd_relay_t exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_chan(input rmcd_chan_t got, input rmcd_chan_t exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // relay, indicator and active flag against one expected vector
    task automatic check_relays(input rmcd_relay_t exp);
        cmp_relay(relay_en, exp);
        cmp_relay(chan_led, exp);
        cmp_bit(chan_active, exp != 16'h0000);
    endtask

    // outputs dark after reset, also after a mid-run reset
    task automatic t_reset();
        check_relays(16'h0000);
        cmp_bit(settling, 1'b0);
    endtask

    // every channel in turn, each releasing the one before
    task automatic t_channels();
        for (int ch = 0; ch < 16; ch++) begin
            host.set_chan(ch[3:0], DEV);
            check_relays(16'h0001 << ch);
            cmp_chan(chan_num, ch[3:0]);
            cmp_bit(settling, 1'b1);
            host.settle();
            cmp_bit(settling, 1'b0);
        end
    endtask

    // set and all-off for other addresses leave the unit alone
    task automatic t_foreign();
        for (int a = 0; a < 4; a++) begin
            if (a[1:0] != DEV) begin
                host.set_chan(4'h5, a[1:0]);
                check_relays(16'h8000);
                host.all_off(a[1:0]);
                check_relays(16'h8000);
                host.settle();
            end
        end
    endtask

    // all-off for this unit, then recovery
    task automatic t_all_off();
        host.all_off(DEV);
        check_relays(16'h0000);
        host.settle();
        host.set_chan(4'h3, DEV);
        check_relays(16'h0008);
        host.settle();
    endtask

    // selection and strobe in one word: fields of the strobe word ignored
    task automatic t_same_sample();
        host.put({2'b01, DEV, 4'h9}, 4);
        check_relays(16'h0008);
        host.settle();
    endtask

    // set and all-off in one word for this unit: all-off wins
    task automatic t_off_wins();
        host.put({2'b00, DEV, 4'h6}, 4);
        host.put({2'b11, DEV, 4'h0}, 4);
        check_relays(16'h0000);
        cmp_bit(settling, 1'b1);
        host.settle();
        check_relays(16'h0000);
    endtask

    // report and end the run
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog
    initial begin
        #(25 * 5000);
        mismatches++;
        wrap_up();
    end

    // main sequence
    initial begin
        sys_clk_i  = 1'b0;
        nrst_i     = 1'b0;
        mismatches = 0;
        checked    = 0;
        repeat (10) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        @(negedge sys_clk_i);
        t_reset();
        t_channels();
        t_foreign();
        t_all_off();
        t_same_sample();
        t_off_wins();
        nrst_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        @(negedge sys_clk_i);
        t_reset();
        wrap_up();
    end
endmodule
